// ### sdis_card.sv
// Purpose: card in slot
// Assumes: bench sets levels
// Notes: clean edges, no bounce
module sdis_card(output logic CARD_DETECT_I=0,CARD_IRQ_I=0);
	timeunit 1ns/1ps;
endmodule

// ### sdis_defines.vh
// Purpose: constants for the sd host interrupt status flag bank
// Assumes: 32-bit register port, word index addressing
// Notes: offsets are word indices on the plain register port
`ifndef SDIS_DEFINES_VH
`define SDIS_DEFINES_VH
`define SDIS_ADDR_W 4
`define SDIS_STAT_ADDR 4'h0
`define SDIS_RAW_ADDR 4'h1
`define SDIS_BIT_CMD 0
`define SDIS_BIT_XFER 1
`define SDIS_BIT_GAP 2
`define SDIS_BIT_DMA 3
`define SDIS_BIT_WRDY 4
`define SDIS_BIT_RRDY 5
`define SDIS_BIT_INS 6
`define SDIS_BIT_REM 7
`define SDIS_BIT_CARD 8
`define SDIS_FLAG_W 8
`define SDIS_STAT_RST 32'h0000_0000
`define SDIS_DEBOUNCE_NS 1000
`define SDIS_CLK_MHZ 250
`endif

// ### sdis_flags.v
// Purpose: interrupt status flags of an sd host controller
// Assumes: event inputs are one-cycle pulses on CLK_I
// Notes: card detect pin is synchronised and debounced here
//
// Added by the designer: the address map and the plain strobed port.
`include "sdis_defines.vh"

module sdis_flags #(
	parameter DEBOUNCE_CYC = (`SDIS_DEBOUNCE_NS * `SDIS_CLK_MHZ + 999) / 1000
) (
	input wire CLK_I,
	input wire RST_N_I,
	input wire [`SDIS_ADDR_W-1:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	input wire CARD_DETECT_I,
	input wire CARD_IRQ_I,
	input wire RD_READY_I,
	input wire WR_READY_I,
	input wire DMA_EVENT_I,
	input wire BLOCK_GAP_I,
	input wire XFER_DONE_I,
	input wire CMD_DONE_I,
	output wire IRQ_O
);

	localparam CW = 16;

	reg det_s1;
	reg det_s2;
	reg irq_s1;
	reg irq_s2;
	reg det_stable;
	reg [CW-1:0] db_cnt;
	reg [`SDIS_FLAG_W-1:0] flags;
	reg [`SDIS_FLAG_W-1:0] next_flags;
	reg [`SDIS_FLAG_W-1:0] set_vec;
	reg ins_evt;
	reg rem_evt;
	wire wr_stat;

	// two-flop synchronisers for pin inputs
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			det_s1 <= 1'b0;
			det_s2 <= 1'b0;
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
		end else begin
			det_s1 <= CARD_DETECT_I;
			det_s2 <= det_s1;
			irq_s1 <= CARD_IRQ_I;
			irq_s2 <= irq_s1;
		end
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			det_stable <= 1'b0;
			db_cnt <= {CW{1'b0}};
			ins_evt <= 1'b0;
			rem_evt <= 1'b0;
		end else begin
			ins_evt <= 1'b0;
			rem_evt <= 1'b0;
			if (det_s2 == det_stable) begin
				db_cnt <= {CW{1'b0}};
			end else if (db_cnt == DEBOUNCE_CYC[CW-1:0] - 1'b1) begin
				db_cnt <= {CW{1'b0}};
				det_stable <= det_s2;
				ins_evt <= det_s2;
				rem_evt <= ~det_s2;
			end else begin
				db_cnt <= db_cnt + 1'b1;
			end
		end
	end

	assign wr_stat = WR_I && (ADDR_I == `SDIS_STAT_ADDR);

	// sticky flag update, set beats clear
	always @* begin
		set_vec = {`SDIS_FLAG_W{1'b0}};
		set_vec[`SDIS_BIT_CMD] = CMD_DONE_I;
		set_vec[`SDIS_BIT_XFER] = XFER_DONE_I;
		set_vec[`SDIS_BIT_GAP] = BLOCK_GAP_I;
		set_vec[`SDIS_BIT_DMA] = DMA_EVENT_I;
		set_vec[`SDIS_BIT_WRDY] = WR_READY_I;
		set_vec[`SDIS_BIT_RRDY] = RD_READY_I;
		set_vec[`SDIS_BIT_INS] = ins_evt;
		set_vec[`SDIS_BIT_REM] = rem_evt;
		next_flags = flags;
		if (wr_stat) begin
			next_flags = next_flags & ~WDATA_I[`SDIS_FLAG_W-1:0];
		end
		next_flags = next_flags | set_vec;
	end

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			flags <= {`SDIS_FLAG_W{1'b0}};
		end else begin
			flags <= next_flags;
		end
	end

	// read data, one cycle after strobe
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RDATA_O <= `SDIS_STAT_RST;
		end else if (RD_I) begin
			case (ADDR_I)
				// live card interrupt; upper bits zero
				`SDIS_STAT_ADDR: RDATA_O <= {23'h0, irq_s2, flags};
				`SDIS_RAW_ADDR: RDATA_O <= {30'h0, det_stable, det_s2};
				default: RDATA_O <= 32'h0000_0000;
			endcase
		end else begin
			RDATA_O <= 32'h0000_0000;
		end
	end

	assign IRQ_O = (|flags) | irq_s2;

endmodule

// ### sdis_flags_tb.sv
// Purpose: sdis_flags bench
// Assumes: debounce cut to 4
// Notes: rows pulse each of the six e event inputs
module sdis_flags_tb;
	timeunit 1ns/1ps;
	logic CLK_I=0,RST_N_I=0,WR_I=0,RD_I=0,IRQ_O,CARD_DETECT_I,CARD_IRQ_I;
	logic [3:0] ADDR_I=0;
	logic [31:0] WDATA_I=0,RDATA_O;
	logic [5:0] e=0,row[6]='{6'h1,6'h2,6'h4,6'h8,6'h10,6'h20};
	int errors=0,total_checks=0;
	always #2 CLK_I=~CLK_I;
	sdis_card card(.*);
	sdis_flags #(4) dut(.*,.CMD_DONE_I(e[0]),.XFER_DONE_I(e[1]),
		.BLOCK_GAP_I(e[2]),.DMA_EVENT_I(e[3]),.WR_READY_I(e[4]),
		.RD_READY_I(e[5]));
	task end_of_test;
		$display("%0d checks %0d errors",total_checks,errors);
		if(errors==0&&total_checks>0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// read strobe now, check in the answer cycle
	task chk(input string n,input logic [31:0] x,y);
		total_checks++;
		if(x!==y) begin
			errors++;
			$display("[ERR] %s exp %h got %h",n,x,y);
		end
	endtask
	task rd(input logic [31:0] x,input logic [3:0] a=4'h0);
		{ADDR_I,RD_I}<={a,1'b1};
		@(posedge CLK_I) RD_I<=0;
		#1 chk("RDATA_O",x,RDATA_O);
	endtask
	task wr(input logic [31:0] x);
		{ADDR_I,WDATA_I,WR_I}<={4'h0,x,1'b1};
		@(posedge CLK_I) WR_I<=0;
	endtask
	initial begin
		repeat(2) @(posedge CLK_I);
		RST_N_I<=1;
		rd(0);
		rd(0,4'hf);
		foreach(row[i]) begin
			@(posedge CLK_I) e<=row[i];
			@(posedge CLK_I) e<=0;
			rd({26'h0,row[i]});
			chk("IRQ_O",1,IRQ_O);
			wr({26'h0,row[i]});
			rd(0);
			chk("IRQ_O",0,IRQ_O);
		end
		// sync 2, debounce 4, pulse 1, flag 1
		card.CARD_DETECT_I<=1;
		rd(0);
		repeat(8) @(posedge CLK_I);
		rd(32'h40);
		rd(32'h3,4'h1);
		wr(32'h40);
		card.CARD_DETECT_I<=0;
		repeat(9) @(posedge CLK_I);
		rd(32'h80);
		card.CARD_IRQ_I<=1;
		repeat(3) @(posedge CLK_I);
		wr(32'h180);
		rd(32'h100);
		card.CARD_IRQ_I<=0;
		repeat(3) @(posedge CLK_I);
		rd(0);
		// flag set, then reset in mid-run
		@(posedge CLK_I) e<=1;
		@(posedge CLK_I) e<=0;
		RST_N_I<=0;
		@(posedge CLK_I) RST_N_I<=1;
		#1 chk("IRQ_O",0,IRQ_O);
		rd(0);
		end_of_test;
	end
endmodule

// ### sdis_props.sv
// Purpose: port checks
// Assumes: 1 clock
// Notes: bind below
module sdis_props(input wire CLK_I,RST_N_I,RD_I,WR_I,IRQ_O,CMD_DONE_I,
	CARD_IRQ_I,input wire [3:0] ADDR_I,input wire [31:0] WDATA_I,RDATA_O);
	timeunit 1ns/1ps;
	default clocking @(posedge CLK_I);endclocking
	default disable iff(!RST_N_I);
	sequence s_r;RD_I&&ADDR_I==4'h0;endsequence
	// read data and IRQ_O against flag causes
	property p_hi;s_r|=>RDATA_O[31:9]==23'h0;endproperty
	a_hi:assert property(p_hi)else $error("hi");
	property p_un;RD_I&&ADDR_I>4'h1|=>RDATA_O==32'h0;endproperty
	a_un:assert property(p_un)else $error("un");
	property p_cm;CMD_DONE_I##1 s_r|=>RDATA_O[0];endproperty
	a_cm:assert property(p_cm)else $error("cm");
	property p_st;CMD_DONE_I##1!WR_I##1 s_r|=>RDATA_O[0];endproperty
	a_st:assert property(p_st)else $error("st");
	property p_cl;WR_I&&ADDR_I==4'h0&&WDATA_I[0]&&!CMD_DONE_I##1 s_r
		|=>!RDATA_O[0];endproperty
	a_cl:assert property(p_cl)else $error("cl");
	property p_iq;CMD_DONE_I|=>IRQ_O;endproperty
	a_iq:assert property(p_iq)else $error("iq");
	property p_c1;CARD_IRQ_I[*3]##1 s_r|=>RDATA_O[8];endproperty
	a_c1:assert property(p_c1)else $error("c1");
	property p_c0;(!CARD_IRQ_I)[*3]##1 s_r|=>!RDATA_O[8];endproperty
	a_c0:assert property(p_c0)else $error("c0");
	// main scenarios
	cover property(CMD_DONE_I##1 s_r);
	cover property(CARD_IRQ_I[*3]##1 s_r);
	cover property(WR_I&&WDATA_I[0]);
endmodule
bind sdis_flags sdis_props u_p(.*);
